// file: chan_status_pkg.sv
//==============================================================
package chan_status_pkg;
  //==============================================================
  // Register map
  localparam logic [7:0] STATUS_ADDR = 8'h47;     // Error status register
  localparam logic [7:0] CAP_ADDR = 8'h4A;        // Capability control register
  localparam logic [7:0] STATUS_RESET = 8'h00;    // Status reset value
  localparam logic [7:0] CAP_RESET = 8'h00;       // Capability reset value
  localparam logic [7:0] CAP_WRITE_MASK = 8'h10;  // Only the CRC flag enable is writable
  localparam logic ENH_ENABLE_RESET = 1'b1;       // Enhanced checking default elsewhere
  //==============================================================
  // Status field positions
  localparam int SEQ_BIT = 5;
  localparam int INIT_ERR_BIT = 4;
  localparam int INIT_TO_BIT = 3;
  localparam int RESP_ERR_BIT = 2;
  localparam int RESP_TO_BIT = 1;
  localparam int DATA_ERR_BIT = 0;
  // Capability field position
  localparam int ENC_CRC_EN_BIT = 4;
  //==============================================================
  // Per-port events from the control channel logic
  typedef struct packed {
    logic sequence_error;     // Forward channel sequence error pulse
    logic fwd_error;          // Sequence, CRC or lock error pulse
    logic watchdog_expire;    // Watchdog timer expiry pulse
    logic response_mismatch;  // Returned data check failed pulse
    logic awaiting_response;  // Level: waiting for serializer
    logic initiator_active;   // Level: local I2C initiator role active
    logic responder_active;   // Level: local I2C responder role active
    logic seq_status_mirror;  // Level: sequence bit of port status one
    logic encoder_crc_error;  // Encoder CRC error pulse
  } chan_event_s;
endpackage

// file: chan_port_regs.sv
`timescale 1ns/1ps
`default_nettype none
module chan_port_regs
  import chan_status_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register access for this copy
  input wire logic wr_cap,
  input wire logic rd_status,
  input wire logic [7:0] wdata,
  // Control channel side
  input wire logic enh_en,
  input wire chan_event_s ev,
  // Register contents and gated flag
  output logic [7:0] status_val,
  output logic [7:0] cap_val,
  output logic enc_crc_flag
);
  //==============================================================
  // Sticky state
  logic seq_r, init_err_r, init_to_r, resp_err_r, resp_to_r, data_err_r; // Flags
  logic crc_en_r;            // Encoder CRC flag enable
  logic wait_init, wait_resp; // Waiting in each role
  assign wait_init = ev.awaiting_response && ev.initiator_active;
  assign wait_resp = ev.awaiting_response && ev.responder_active;

  // Sequence flag: sticky in both modes, read back only in enhanced mode, set wins over read clear
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      seq_r <= 1'b0;
    end else if (ev.sequence_error) begin
      seq_r <= 1'b1;
    end else if (rd_status) begin
      seq_r <= 1'b0;
    end
  end

  // Role errors; only recorded with enhanced checking on
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      init_err_r <= 1'b0;
      resp_err_r <= 1'b0;
    end else begin
      // Initiator role
      if (enh_en && ev.fwd_error && wait_init) begin
        init_err_r <= 1'b1;
      end else if (rd_status) begin
        init_err_r <= 1'b0;
      end
      // Responder role
      if (enh_en && ev.fwd_error && wait_resp) begin
        resp_err_r <= 1'b1;
      end else if (rd_status) begin
        resp_err_r <= 1'b0;
      end
    end
  end

  // Timeouts; responder timeout is reported regardless of enhanced mode
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      init_to_r <= 1'b0;
      resp_to_r <= 1'b0;
    end else begin
      if (enh_en && ev.watchdog_expire && wait_init) begin
        init_to_r <= 1'b1;
      end else if (rd_status) begin
        init_to_r <= 1'b0;
      end
      if (ev.watchdog_expire && wait_resp) begin
        resp_to_r <= 1'b1;
      end else if (rd_status) begin
        resp_to_r <= 1'b0;
      end
    end
  end

  // Returned data check; relies on the serializer echoing data
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      data_err_r <= 1'b0;
    end else if (enh_en && ev.response_mismatch) begin
      data_err_r <= 1'b1;
    end else if (rd_status) begin
      data_err_r <= 1'b0;
    end
  end

  // Capability enable, writable bit only
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      crc_en_r <= CAP_RESET[ENC_CRC_EN_BIT];
    end else if (wr_cap) begin
      crc_en_r <= wdata[ENC_CRC_EN_BIT];
    end
  end

  // Encoder CRC flag, gated by the enable
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      enc_crc_flag <= 1'b0;
    end else begin
      enc_crc_flag <= crc_en_r && ev.encoder_crc_error;
    end
  end

  // Read views; reserved bits forced to zero
  always_comb begin
    status_val = STATUS_RESET;
    status_val[SEQ_BIT] = enh_en ? seq_r : ev.seq_status_mirror;
    status_val[INIT_ERR_BIT] = init_err_r;
    status_val[INIT_TO_BIT] = init_to_r;
    status_val[RESP_ERR_BIT] = resp_err_r;
    status_val[RESP_TO_BIT] = resp_to_r;
    status_val[DATA_ERR_BIT] = data_err_r;
    cap_val = CAP_RESET;
    cap_val[ENC_CRC_EN_BIT] = crc_en_r;
  end
endmodule
`default_nettype wire

// file: chan_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module chan_status_regs
  import chan_status_pkg::*;
#(
  parameter int NUM_PORTS = 4  // Receive ports
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register access from the I2C target
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Port select, held outside this block
  input wire logic [1:0] read_port_sel,
  input wire logic [3:0] write_port_en,
  // Enhanced error check enable, held outside this block
  input wire logic enhanced_error_check_enable,
  // Per-port control channel events
  input wire chan_event_s [NUM_PORTS-1:0] chan_ev,
  // Gated encoder CRC error flags
  output logic [NUM_PORTS-1:0] encoder_crc_error_flag
);
  //==============================================================
  // Elaboration check
  if (NUM_PORTS < 1 || NUM_PORTS > 4) begin : g_bad_ports
    $error("NUM_PORTS must lie between 1 and 4");
  end

  //==============================================================
  // Decode
  logic [7:0] status_v [NUM_PORTS];  // Status copies
  logic [7:0] cap_v [NUM_PORTS];     // Capability copies
  logic hit_status, hit_cap;         // Address hits
  assign hit_status = reg_addr == STATUS_ADDR;
  assign hit_cap = reg_addr == CAP_ADDR;

  // One copy per port; writes may broadcast, reads hit one port
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    chan_port_regs u_regs (
      .mclk(mclk),
      .nrst(nrst),
      .wr_cap(reg_wr && hit_cap && write_port_en[p]),
      .rd_status(reg_rd && hit_status && read_port_sel == 2'(p)),
      .wdata(reg_wdata),
      .enh_en(enhanced_error_check_enable),
      .ev(chan_ev[p]),
      .status_val(status_v[p]),
      .cap_val(cap_v[p]),
      .enc_crc_flag(encoder_crc_error_flag[p])
    );
  end

  //==============================================================
  // Read data, registered; value before the clear is returned
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      // Unselected or unmapped reads return zero
      if (!reg_rd || int'(read_port_sel) >= NUM_PORTS) begin
        reg_rdata <= 8'h00;
      end else if (hit_status) begin
        reg_rdata <= status_v[read_port_sel];
      end else if (hit_cap) begin
        reg_rdata <= cap_v[read_port_sel];
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// file: chan_status_props.sv
`timescale 1ns/1ps
`default_nettype none
module chan_status_props
  import chan_status_pkg::*;
#(
  parameter int NUM_PORTS = 4
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Selects and enable
  input wire logic [1:0] read_port_sel,
  input wire logic [3:0] write_port_en,
  input wire logic enhanced_error_check_enable,
  // Events and gated flags
  input wire chan_event_s [NUM_PORTS-1:0] chan_ev,
  input wire logic [NUM_PORTS-1:0] encoder_crc_error_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  //==============================================================
  // Helpers: port zero only, to keep the checks short
  wire logic rd0 = reg_rd && reg_addr == STATUS_ADDR && read_port_sel == 2'd0;
  wire logic enh = enhanced_error_check_enable;
  wire chan_event_s e0 = chan_ev[0];
  // No pulse that could set a flag
  wire logic quiet = !(e0.sequence_error || e0.fwd_error || e0.watchdog_expire || e0.response_mismatch);
  //==============================================================
  // Checks
  chk_read_answer: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer out of step");
  chk_unmapped_zero: assert property (reg_rd && reg_addr != STATUS_ADDR && reg_addr != CAP_ADDR
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_reserved_zero: assert property (reg_rd |=> reg_rdata[7:6] == 2'h0)
    else $error("reserved bits not zero");
  chk_crc_gate: assert property (encoder_crc_error_flag[0] |-> $past(e0.encoder_crc_error))
    else $error("crc flag without cause");
  chk_seq_mirror: assert property (rd0 && !enh |=> reg_rdata[5] == $past(e0.seq_status_mirror))
    else $error("sequence flag not mirrored");
  chk_seq_set: assert property (e0.sequence_error && enh ##1 rd0 && enh |=> reg_rdata[5])
    else $error("sequence flag not set");
  chk_init_error: assert property (e0.fwd_error && e0.awaiting_response && e0.initiator_active && enh
    ##1 rd0 && enh |=> reg_rdata[4]) else $error("initiator error not set");
  chk_resp_timeout: assert property (e0.watchdog_expire && e0.awaiting_response && e0.responder_active
    ##1 rd0 |=> reg_rdata[1]) else $error("responder timeout not set");
  chk_resp_mismatch: assert property (e0.response_mismatch && enh ##1 rd0 && enh |=> reg_rdata[0])
    else $error("response error not set");
  chk_read_clears: assert property (rd0 && enh && quiet ##1 rd0 && enh |=> reg_rdata[5:0] == 6'h00)
    else $error("flags not cleared by read");
endmodule
bind chan_status_regs chan_status_props #(.NUM_PORTS(NUM_PORTS)) u_props (.mclk(mclk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .read_port_sel(read_port_sel), .write_port_en(write_port_en),
  .enhanced_error_check_enable(enhanced_error_check_enable), .chan_ev(chan_ev),
  .encoder_crc_error_flag(encoder_crc_error_flag));
`default_nettype wire

// file: chan_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module chan_far_model
  import chan_status_pkg::*;
#(
  parameter int NUM_PORTS = 4
)
(
  // Clock
  input wire logic mclk,
  // Event lines toward the block
  output var chan_event_s [NUM_PORTS-1:0] chan_ev
);
  initial chan_ev = '0;
  //==============================================================
  // Pulses last one cycle; levels stay up so roles look real
  task automatic fire(input logic [NUM_PORTS-1:0] pm, input chan_event_s e);
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (pm[p]) begin
        chan_ev[p] = e; // Mismatch pulse stands for a bad echo
      end
    end
    @(posedge mclk);
    #1;
    for (int p = 0; p < NUM_PORTS; p++) begin
      chan_ev[p] = chan_ev[p] & 9'h01E;
    end
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import chan_status_pkg::*;
;
  logic mclk, nrst, reg_wr, reg_rd, enh, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
  logic [1:0] sel;
  logic [3:0] wen, crc_flag;
  chan_event_s [3:0] chan_ev;
  int mismatches = 0, n_compared = 0, cyc = 0;
  chan_status_regs #(.NUM_PORTS(4)) u_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .read_port_sel(sel), .write_port_en(wen), .enhanced_error_check_enable(enh), .chan_ev(chan_ev),
    .encoder_crc_error_flag(crc_flag));
  chan_far_model #(.NUM_PORTS(4)) u_far (.mclk(mclk), .chan_ev(chan_ev));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  //==============================================================
  // Access and compare tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a);
    reg_addr = a;
    reg_wdata = 8'hFF;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    // Idle edge, so a following call never re-raises the strobe in this step
    @(posedge mclk);
    #1;
  endtask
  // Missing answer turns into unknown data
  task automatic rd(input logic [7:0] a, input logic [1:0] p);
    reg_addr = a;
    sel = p;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    got = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    // Idle edge between reads keeps one assignment per step
    @(posedge mclk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard, far above the run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  //==============================================================
  // Main sequence
  initial begin
    {nrst, reg_wr, reg_rd, sel, wen, reg_addr, reg_wdata} = '0;
    enh = 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    nrst = 1'b1;
    wen = 4'h5;
    wr(CAP_ADDR);
    wr(STATUS_ADDR);
    wr(8'h48);
    for (int p = 0; p < 4; p++) begin
      rd(STATUS_ADDR, p[1:0]);
      check("status", got, STATUS_RESET);
      rd(CAP_ADDR, p[1:0]);
      check("cap", got, p[0] ? CAP_RESET : 8'h10);
    end
    rd(8'h48, 2'd0);
    check("unmapped", got, 8'h00);
    // Encoder CRC disable lives elsewhere and is taken as cleared
    u_far.fire(4'hF, 9'h001);
    check("crc flags", {4'h0, crc_flag}, 8'h05);
    // Flag stands one cycle only; the edge also parts two model calls
    @(posedge mclk);
    #1;
    check("crc flags off", {4'h0, crc_flag}, 8'h00);
    // Initiator role, every pulse but the encoder CRC error at once
    u_far.fire(4'h1, 9'h1F8);
    rd(STATUS_ADDR, 2'd0);
    check("status", got, 8'h39);
    rd(STATUS_ADDR, 2'd0);
    check("status", got, 8'h00);
    rd(STATUS_ADDR, 2'd1);
    check("other port", got, 8'h00);
    // Responder role, then no wait for a response
    u_far.fire(4'h1, 9'h0D4);
    rd(STATUS_ADDR, 2'd0);
    check("status", got, 8'h06);
    u_far.fire(4'h1, 9'h0C4);
    rd(STATUS_ADDR, 2'd0);
    check("status", got, 8'h00);
    // Enhanced checking off: only mirror and timeout show
    enh = 1'b0;
    u_far.fire(4'h1, 9'h0F6);
    rd(STATUS_ADDR, 2'd0);
    check("status", got, 8'h22);
    rd(STATUS_ADDR, 2'd0);
    check("status", got, 8'h20);
    tally_and_finish();
  end
endmodule
`default_nettype wire
